// file: rtl/ucb_map.vh
`ifndef UCB_MAP_VH
`define UCB_MAP_VH
`define UCB_ADDR_CFG      12'h000
`define UCB_ADDR_STATUS   12'h004
`define UCB_ADDR_FRAME    12'h008
`define UCB_ADDR_REGION   12'h00c
`define UCB_CFG_RESET     8'hff
`define UCB_BIT_CODE_SIZE_SELECT     7
`define UCB_BIT_INTERRUPT_FRAME_MODE      4
`define UCB_BIT_WSB       3
`define UCB_BIT_WCNT_HI   2
`define UCB_BIT_WCNT_LO   1
`define UCB_BIT_CODE_TO_DATA_ALIAS_OFF      0
`define UCB_RSVD_MASK     8'h60
`define UCB_CODE_SIZE_SELECT_MASK    8'h80
`define UCB_FRAME_SHORT   3'h2
`define UCB_FRAME_LONG    3'h4
`define UCB_SEG_01        8'h01
`define UCB_SEG_00        8'h00
`define UCB_ALIAS_HI      2'h3
`define UCB_CODE16_TOP    16'h3fff
`define UCB_CODE32_TOP    16'h7fff
`define UCB_ALIAS_BASE    16'h4000
`endif

// file: rtl/ucb_wait_decode.v
`timescale 1ns/1ps
`include "ucb_map.vh"
module ucb_wait_decode (
  input  wire [7:0] cfg,
  output reg  [1:0] wait_states
);
  always @* begin
    // Active-low count; the legacy bit forces one wait when cleared
    if (!cfg[`UCB_BIT_WSB]) begin
      wait_states = 2'h1;
    end else begin
      wait_states = ~{cfg[`UCB_BIT_WCNT_HI], cfg[`UCB_BIT_WCNT_LO]};
    end
  end
endmodule

// file: rtl/ucb_config_decode.v
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ucb_map.vh"
// Overview of operation
// - Bit 7 selects 16 or 32 KB code
// - Bit 4 selects two or four byte frame
// - Interrupt return pops matching byte count
// - Bit 3 clear forces exactly one region-01 wait
// - Bit 0 clear aliases upper code into data
module ucb_config_decode #(
  parameter HAS_CODE_SIZE = 1
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         code_size_32k,
  output reg  [2:0]  interrupt_frame_mode_push_bytes,
  output reg  [2:0]  interrupt_frame_mode_pop_bytes,
  output reg         region01_wait_active,
  output reg  [1:0]  region01_wait_states,
  output reg         code_alias_en,
  output reg  [15:0] code_top_addr,
  input  wire [7:0]  data_seg,
  input  wire [15:0] data_addr,
  output reg         alias_hit,
  output reg  [15:0] alias_code_addr
);
  reg  [7:0]  user_config_byte_one_reg;
  reg  [7:0]  cfg_next;
  reg  [31:0] rdata_next;
  reg         err_next;
  reg         rsvd_warn_reg;
  wire [1:0]  wait_dec;
  wire        acc;
  wire        wr;

  assign acc = psel && !penable;
  // Write lands at the edge where the master samples pready high
  assign wr  = psel && penable && pready && pwrite;

  ucb_wait_decode u_wait (
    .cfg         (user_config_byte_one_reg),
    .wait_states (wait_dec)
  );

  always @* begin
    cfg_next   = user_config_byte_one_reg;
    rdata_next = 32'h0;
    err_next   = 1'b0;
    case (paddr)
      `UCB_ADDR_CFG: begin
        if (pwrite) begin
          cfg_next = pwdata[7:0];
          if (HAS_CODE_SIZE == 0) begin
            cfg_next = pwdata[7:0] | `UCB_CODE_SIZE_SELECT_MASK;
          end
        end
        rdata_next = {24'h0, user_config_byte_one_reg};
      end
      `UCB_ADDR_STATUS: rdata_next = {31'h0, rsvd_warn_reg};
      `UCB_ADDR_FRAME:  rdata_next = {26'h0, interrupt_frame_mode_pop_bytes, interrupt_frame_mode_push_bytes};
      `UCB_ADDR_REGION: rdata_next = {29'h0, region01_wait_active, region01_wait_states};
      default:          err_next = 1'b1;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      user_config_byte_one_reg <= `UCB_CFG_RESET;
      rsvd_warn_reg            <= 1'b0;
      prdata                   <= 32'h0;
      pready                   <= 1'b0;
      pslverr                  <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc && err_next;
      prdata  <= acc ? rdata_next : 32'h0;
      if (wr && !err_next) begin
        user_config_byte_one_reg <= cfg_next;
        if (paddr == `UCB_ADDR_CFG) begin
          // Flags a writer that left reserved bits cleared
          rsvd_warn_reg <= ((pwdata[7:0] & `UCB_RSVD_MASK) != `UCB_RSVD_MASK);
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      code_size_32k        <= 1'b1;
      interrupt_frame_mode_push_bytes      <= `UCB_FRAME_LONG;
      interrupt_frame_mode_pop_bytes       <= `UCB_FRAME_LONG;
      region01_wait_active <= 1'b0;
      region01_wait_states <= 2'h0;
      code_alias_en        <= 1'b0;
      code_top_addr        <= `UCB_CODE32_TOP;
      alias_hit            <= 1'b0;
      alias_code_addr      <= 16'h0;
    end else begin
      code_size_32k <= user_config_byte_one_reg[`UCB_BIT_CODE_SIZE_SELECT];
      code_top_addr <= user_config_byte_one_reg[`UCB_BIT_CODE_SIZE_SELECT] ?
                       `UCB_CODE32_TOP : `UCB_CODE16_TOP;
      // Push and pop follow the same live bit, so frames always match
      interrupt_frame_mode_push_bytes <= user_config_byte_one_reg[`UCB_BIT_INTERRUPT_FRAME_MODE] ?
                         `UCB_FRAME_LONG : `UCB_FRAME_SHORT;
      interrupt_frame_mode_pop_bytes  <= user_config_byte_one_reg[`UCB_BIT_INTERRUPT_FRAME_MODE] ?
                         `UCB_FRAME_LONG : `UCB_FRAME_SHORT;
      region01_wait_states <= wait_dec;
      region01_wait_active <= (data_seg == `UCB_SEG_01) && (wait_dec != 2'h0);
      code_alias_en <= !user_config_byte_one_reg[`UCB_BIT_CODE_TO_DATA_ALIAS_OFF];
      alias_hit     <= !user_config_byte_one_reg[`UCB_BIT_CODE_TO_DATA_ALIAS_OFF] &&
                       (data_seg == `UCB_SEG_00) &&
                       (data_addr[15:14] == `UCB_ALIAS_HI);
      alias_code_addr <= `UCB_ALIAS_BASE | {2'h0, data_addr[13:0]};
    end
  end
endmodule

// file: sim/ucb_props.sv
`timescale 1ns/1ps
module ucb_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        code_size_32k,
  input wire logic [15:0] code_top_addr,
  input wire logic [2:0]  interrupt_frame_mode_push_bytes,
  input wire logic [2:0]  interrupt_frame_mode_pop_bytes
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_top; code_top_addr == (code_size_32k ? 16'h7fff : 16'h3fff); endproperty
  a_top: assert property (p_top) else $error("top");
  property p_frm; interrupt_frame_mode_push_bytes == 3'h2 || interrupt_frame_mode_push_bytes == 3'h4; endproperty
  a_frm: assert property (p_frm) else $error("frame");
  property p_pop; interrupt_frame_mode_pop_bytes == interrupt_frame_mode_push_bytes; endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_chf; $changed(interrupt_frame_mode_push_bytes) |-> $past(pready, 2); endproperty
  a_chf: assert property (p_chf) else $error("frame chg");
  property p_chs; $changed(code_size_32k) |-> $past(pready, 2); endproperty
  a_chs: assert property (p_chs) else $error("size chg");
endmodule
bind ucb_config_decode ucb_props u_props (.*);

// file: sim/ucb_config_decode_tb.sv
`timescale 1ns/1ps
module ucb_config_decode_tb;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic code_size_32k, code_alias_en, alias_hit, region01_wait_active;
  logic [2:0] interrupt_frame_mode_push_bytes, interrupt_frame_mode_pop_bytes;
  logic [1:0] region01_wait_states;
  logic [7:0] data_seg = 0;
  logic [11:0] paddr = 0;
  logic [15:0] code_top_addr, alias_code_addr, data_addr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] wv [5] = '{8'hf7, 8'hff, 8'hfd, 8'hfb, 8'hf9};
  logic [1:0] we [5] = '{1, 0, 1, 2, 3};
  int n_errors = 0, n_tests = 0;
  ucb_config_decode dut (.*);
  initial forever #2 core_clk = ~core_clk;
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    repeat (2) @(negedge core_clk);
  endtask
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("%0d checks, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    xfer(0, 12'h008, 0);
    chk(rd, 32'h24);
    chk(code_top_addr, 16'h7fff);
    chk(er, 1'b0);
    chk(code_alias_en, 1'b0);
    xfer(1, 12'h000, 8'h6f);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h12);
    chk(interrupt_frame_mode_push_bytes, 3'h2);
    chk(code_size_32k, 1'b0);
    chk(code_top_addr, 16'h3fff);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h0);
    xfer(1, 12'h000, 8'h9f);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h1);
    xfer(1, 12'h000, 8'hff);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h24);
    chk(interrupt_frame_mode_push_bytes, 3'h4);
    $display("frame and size test done");
    @(posedge core_clk) data_seg <= 8'h01;
    for (int i = 0; i < 5; i++) begin
      xfer(1, 12'h000, wv[i]);
      chk(region01_wait_states, we[i]);
      chk(region01_wait_active, we[i] != 0);
    end
    $display("wait test done");
    xfer(1, 12'h000, 8'hfe);
    @(posedge core_clk) {data_seg, data_addr} <= {8'h00, 16'hc123};
    repeat (2) @(negedge core_clk);
    chk(alias_hit, 1'b1);
    chk(code_alias_en, 1'b1);
    chk(alias_code_addr, 16'h4123);
    $display("alias test done");
    xfer(0, 12'h010, 0);
    chk(er, 1'b1);
    $display("unmapped test done");
    tally_and_finish;
  end
endmodule
